// >>> shared/hbs_if.sv
interface hbs_if;
  import hbs_pkg::*;
  logic chip_sel_n;
  logic write_n;
  logic read_n;
  logic [HBS_ADDR_W-1:0] addr;
  logic [HBS_DATA_W-1:0] d_host;
  logic d_host_oe;
  logic [HBS_DATA_W-1:0] d_dev;
  logic d_dev_oe;
  logic irq_out_n;
  logic reset_n;
  logic bus_style_sel;
  logic addr_mux_sel_n;
  logic strobe_pol_sel_n;
  logic write_timing_sel_n;
  logic standalone_n;
  modport device (
    input chip_sel_n, write_n, read_n, addr, d_host, d_host_oe, reset_n,
    input bus_style_sel, addr_mux_sel_n, strobe_pol_sel_n, write_timing_sel_n,
    input standalone_n,
    output d_dev, d_dev_oe, irq_out_n
  );
  modport host (
    output chip_sel_n, write_n, read_n, addr, d_host, d_host_oe, reset_n,
    output bus_style_sel, addr_mux_sel_n, strobe_pol_sel_n, write_timing_sel_n,
    output standalone_n,
    input d_dev, d_dev_oe, irq_out_n
  );
endinterface : hbs_if

// >>> shared/hbs_pkg.sv
package hbs_pkg;
  localparam int HBS_ADDR_W = 6;
  localparam int HBS_DATA_W = 16;
  localparam int HBS_GPIO_W = 8;
  localparam int HBS_ID_W = 5;
  localparam int HBS_MUX_W = 6;
  // Host command register indices
  localparam logic [1:0] HBS_REG_CTRL = 2'h0;
  localparam logic [1:0] HBS_REG_DATA = 2'h1;
  localparam logic [1:0] HBS_REG_STAT = 2'h2;
  // Control field positions
  localparam int HBS_CTRL_GO = 0;
  localparam int HBS_CTRL_WR = 1;
  localparam logic [15:0] HBS_RST_DATA = 16'h0000;
  typedef enum logic [1:0] {
    HBS_IDLE = 2'b00,
    HBS_ALE = 2'b01,
    HBS_STRB = 2'b10,
    HBS_DONE = 2'b11
  } hbs_state_t;
endpackage : hbs_pkg

// >>> src/hbs_device.sv
// Notes on behaviour
// - Names ending _n are asserted low, but byte_swap_sel_n enables swap when high
// - Straps are fixed levels; open reads high
// - Bus-style strap picks pin meaning; else ID1
// - Write: strobe with direction low, or write pin
// - Mux strap shares data 5:0; else ID0
// - Latch polarity picks falling or rising edge
// - System straps write timing per host style
// - Standalone: write-timing strap is carry bit2
// - Standalone: data pins are input port
// - Standalone: address pins are output port 7:0
// - GPIO pins, or output port 15:8
// - Interrupt pin, or time unlocked flag
// - Chip select gives ID bit4 standalone
// - Node settings by strap or register
// - Strobe strap: polarity, or error stop mode
// - Strap sets transmit-enable polarity
// - Reset low holds reset state
// - Strobe low-active when strap high
// - Read: strobe with direction high, or read pin
module hbs_device
  import hbs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host side
  hbs_if.device hb,
  // Other straps
  input wire logic latch_pol_sel,
  input wire logic bus_width_sel,
  input wire logic byte_swap_sel_n,
  input wire logic tx_en_pol_sel,
  input wire logic [14:0] node_straps,
  input wire logic [14:0] node_regs,
  input wire logic node_reg_use,
  input wire logic [3:0] carry_lo_straps,
  // Core side
  input wire logic irq_req,
  input wire logic time_unlocked_flag,
  input wire logic tx_act1,
  input wire logic tx_act2,
  input wire logic [HBS_DATA_W-1:0] rd_data,
  input wire logic [HBS_GPIO_W-1:0] gpio_out,
  input wire logic [HBS_GPIO_W-1:0] gpio_oe,
  input wire logic [HBS_DATA_W-1:0] standalone_out_port,
  input wire logic out_port_strobe,
  // Decoded outputs
  output logic standalone,
  output logic [HBS_ID_W-1:0] clk_master_id,
  output logic [3:0] carry_digit_sel,
  output logic rx_err_stop_mode,
  output logic [14:0] node_cfg,
  output logic wr_pulse,
  output logic rd_pulse,
  output logic [HBS_ADDR_W-1:0] acc_addr,
  output logic [HBS_DATA_W-1:0] wr_data,
  output logic [HBS_DATA_W-1:0] standalone_in_port,
  output logic in_port_strobe,
  output logic [7:0] pin_out,
  output logic [HBS_GPIO_W-1:0] gpio_pin_out,
  output logic [HBS_GPIO_W-1:0] gpio_pin_oe,
  output logic tx_en_port1,
  output logic tx_en_port2
);
  logic sa_q, rws_q, mux_q, alep_q, dsi_q, w16_q, swp_q, txp_q;
  logic [4:0] id_q;
  logic [3:0] carry_digit_sel_q;
  logic [14:0] node_q;
  logic stb_prev_q, ale_prev_q;
  logic [HBS_MUX_W-1:0] ad_prev_q;
  logic [HBS_ADDR_W-1:0] lat_q;
  logic [HBS_DATA_W-1:0] wd_q, pi_q;
  logic wp_q, rp_q, pis_q;
  logic [7:0] po_q;
  logic [HBS_GPIO_W-1:0] gp_q, gpoe_q;
  logic irq_q, tx1_q, tx2_q;
  logic stb_act, acc_act, ale_now, ale_edge;

  // Straps are caught while reset is low and frozen after release
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sa_q <= ~hb.standalone_n;
      rws_q <= hb.bus_style_sel;
      mux_q <= ~hb.addr_mux_sel_n;
      alep_q <= latch_pol_sel;
      dsi_q <= hb.strobe_pol_sel_n;
      w16_q <= bus_width_sel;
      swp_q <= byte_swap_sel_n;
      txp_q <= tx_en_pol_sel;
      id_q <= {hb.chip_sel_n, byte_swap_sel_n, bus_width_sel, hb.bus_style_sel,
               hb.addr_mux_sel_n};
      carry_digit_sel_q <= {carry_lo_straps[3], hb.write_timing_sel_n, carry_lo_straps[1:0]};
      node_q <= node_straps;
    end
  end

  assign standalone = sa_q;
  assign clk_master_id = sa_q ? id_q : '0;
  assign carry_digit_sel = sa_q ? carry_digit_sel_q : '0;
  assign rx_err_stop_mode = sa_q & dsi_q;
  assign node_cfg = (!sa_q && node_reg_use) ? node_regs : node_q;

  // Strobe level decoded against polarity strap
  assign stb_act = dsi_q ? ~hb.read_n : hb.read_n;
  assign acc_act = !sa_q && !hb.chip_sel_n;
  assign ale_now = hb.addr[2];
  assign ale_edge = alep_q ? (ale_prev_q & ~ale_now) : (~ale_prev_q & ale_now);

  // Edge history
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stb_prev_q <= 1'b0;
    else
      stb_prev_q <= rws_q ? stb_act : ~(hb.read_n & hb.write_n);
  end

  // Tracks the pin through reset, so release shows no false latch edge;
  // the bus copy keeps the address that stood before the edge
  always_ff @(posedge clk)
  begin
    ale_prev_q <= ale_now;
    ad_prev_q <= hb.d_host[HBS_MUX_W-1:0];
  end

  // Address latch; only low six data bits carry address
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lat_q <= '0;
    else if (mux_q && ale_edge)
      lat_q <= {ad_prev_q[HBS_MUX_W-1:1], ad_prev_q[0] & ~w16_q};
    else if (!mux_q)
      lat_q <= {hb.addr[HBS_ADDR_W-1:1], hb.addr[0] & ~w16_q};
  end

  // Access pulses on strobe start; swap only matters in 8-bit mode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      wd_q <= HBS_RST_DATA;
    end
    else
    begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      if (rws_q)
      begin
        if (acc_act && stb_act && !stb_prev_q)
        begin
          wp_q <= ~hb.write_n;
          rp_q <= hb.write_n;
        end
      end
      else if (acc_act && stb_prev_q && hb.read_n && hb.write_n)
        wp_q <= 1'b0;
      else if (acc_act && !stb_prev_q)
      begin
        wp_q <= ~hb.write_n;
        rp_q <= ~hb.read_n;
      end
      if (acc_act)
        wd_q <= (!w16_q && swp_q) ? {hb.d_host[7:0], hb.d_host[15:8]} : hb.d_host;
    end
  end

  assign wr_pulse = wp_q;
  assign rd_pulse = rp_q;
  assign acc_addr = lat_q;
  assign wr_data = wd_q;

  // Standalone port mapping
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pi_q <= '0;
      pis_q <= 1'b0;
      po_q <= '0;
      gp_q <= '0;
      gpoe_q <= '0;
      irq_q <= 1'b1;
      tx1_q <= 1'b0;
      tx2_q <= 1'b0;
    end
    else
    begin
      pi_q <= sa_q ? hb.d_host : '0;
      pis_q <= sa_q & ~hb.d_host[0];
      po_q <= sa_q ? {standalone_out_port[7:1], standalone_out_port[0] & ~out_port_strobe}
                   : '0;
      gp_q <= sa_q ? standalone_out_port[15:8] : gpio_out;
      gpoe_q <= sa_q ? '1 : gpio_oe;
      irq_q <= sa_q ? ~time_unlocked_flag : ~irq_req;
      tx1_q <= tx_act1 ~^ txp_q;
      tx2_q <= tx_act2 ~^ txp_q;
    end
  end

  assign standalone_in_port = pi_q;
  assign in_port_strobe = pis_q;
  assign pin_out = po_q;
  assign gpio_pin_out = gp_q;
  assign gpio_pin_oe = gpoe_q;
  assign tx_en_port1 = tx1_q;
  assign tx_en_port2 = tx2_q;
  assign hb.irq_out_n = irq_q;
  assign hb.d_dev = rd_data;
  assign hb.d_dev_oe = acc_act && (rws_q ? (stb_act && hb.write_n) : !hb.read_n);
endmodule : hbs_device

// >>> src/hbs_host.sv
// Host end: drives straps, performs bus cycles from a command port
module hbs_host
  import hbs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus to device
  hbs_if.host hb,
  // Strap choices
  input wire logic cfg_bus_style,
  input wire logic cfg_mux,
  input wire logic cfg_latch_pol,
  input wire logic cfg_strobe_low,
  input wire logic cfg_cs_early,
  input wire logic cfg_standalone,
  // Command port
  input wire logic [1:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [15:0] cmd_rdata
);
  hbs_state_t st_q;
  logic wr_q, busy_q;
  logic [HBS_ADDR_W-1:0] a_q;
  logic [15:0] d_q, rd_q, out_q;
  logic strobe;
  logic [HBS_ADDR_W-1:0] addr_pins;

  // Command registers and sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= HBS_IDLE;
      wr_q <= 1'b0;
      busy_q <= 1'b0;
      a_q <= '0;
      d_q <= HBS_RST_DATA;
      rd_q <= HBS_RST_DATA;
    end
    else
    begin
      if (cmd_wr && cmd_addr == HBS_REG_DATA)
        d_q <= cmd_wdata;
      case (st_q)
        HBS_IDLE:
        begin
          if (cmd_wr && cmd_addr == HBS_REG_CTRL && cmd_wdata[HBS_CTRL_GO])
          begin
            wr_q <= cmd_wdata[HBS_CTRL_WR];
            a_q <= cmd_wdata[HBS_ADDR_W+7:8];
            busy_q <= 1'b1;
            st_q <= cfg_mux ? HBS_ALE : HBS_STRB;
          end
        end
        HBS_ALE: st_q <= HBS_STRB;
        HBS_STRB:
        begin
          if (!wr_q)
            rd_q <= hb.d_dev;
          st_q <= HBS_DONE;
        end
        HBS_DONE:
        begin
          busy_q <= 1'b0;
          st_q <= HBS_IDLE;
        end
        default: st_q <= HBS_IDLE;
      endcase
    end
  end

  // Strobe level follows chosen polarity in bus-style mode, active high unless cfg_strobe_low is set
  assign strobe = (st_q == HBS_STRB);
  always_comb
  begin
    addr_pins = a_q;
    addr_pins[3] = cfg_latch_pol;
    addr_pins[2] = (st_q == HBS_ALE) ~^ cfg_latch_pol;
    if (!cfg_mux)
      addr_pins = a_q;
  end

  assign hb.reset_n = rst_n;
  assign hb.standalone_n = ~cfg_standalone;
  assign hb.bus_style_sel = cfg_bus_style;
  assign hb.addr_mux_sel_n = ~cfg_mux;
  assign hb.strobe_pol_sel_n = cfg_strobe_low;
  // Early chip-select release needs strap high
  assign hb.write_timing_sel_n = cfg_cs_early;
  assign hb.addr = addr_pins;
  assign hb.chip_sel_n = ~(strobe || (!cfg_cs_early && st_q == HBS_DONE));
  assign hb.write_n = cfg_bus_style ? ~wr_q : ~(strobe && wr_q);
  assign hb.read_n = cfg_bus_style ? (strobe ^ cfg_strobe_low)
                                   : ~(strobe && !wr_q);
  assign hb.d_host = (st_q == HBS_ALE) ? {10'h000, a_q} : d_q;
  assign hb.d_host_oe = (st_q == HBS_ALE) || (strobe && wr_q);

  // Read data one cycle after cmd_rd
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      out_q <= HBS_RST_DATA;
    else if (cmd_rd)
      case (cmd_addr)
        HBS_REG_DATA: out_q <= rd_q;
        HBS_REG_STAT: out_q <= {14'h0000, ~hb.irq_out_n, busy_q};
        default: out_q <= 16'h0000;
      endcase
  end
  assign cmd_rdata = out_q;
endmodule : hbs_host

// >>> tb/hbs_props.sv
module hbs_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus pins
  input wire logic chip_sel_n,
  input wire logic write_n,
  input wire logic read_n,
  input wire logic d_host_oe,
  input wire logic d_dev_oe,
  input wire logic irq_out_n,
  // Straps
  input wire logic bus_style_sel,
  input wire logic addr_mux_sel_n,
  input wire logic strobe_pol_sel_n,
  input wire logic write_timing_sel_n,
  input wire logic standalone_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [4:0] straps;
  assign straps = {bus_style_sel, addr_mux_sel_n, strobe_pol_sel_n, write_timing_sel_n,
    standalone_n};
  // Two cycles of slack: the host may register straps at release
  property p_strap_hold;
    $past(rst_n, 2) |-> $stable(straps);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap moved");
  property p_rw_excl;
    !bus_style_sel |-> write_n || read_n;
  endproperty
  a_rw_excl: assert property (p_rw_excl) else $error("both strobes");
  property p_wr_one;
    !bus_style_sel && $fell(write_n) |=> write_n;
  endproperty
  a_wr_one: assert property (p_wr_one) else $error("long write");
  property p_wr_data;
    !bus_style_sel && !write_n |-> d_host_oe;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write undriven");
  property p_rd_cs;
    !bus_style_sel && !read_n |-> !chip_sel_n;
  endproperty
  a_rd_cs: assert property (p_rd_cs) else $error("read unselected");
  property p_ds_idle;
    bus_style_sel && standalone_n && chip_sel_n && $past(chip_sel_n) && $past(rst_n)
      |-> read_n == strobe_pol_sel_n;
  endproperty
  a_ds_idle: assert property (p_ds_idle) else $error("strobe idle level");
  property p_no_clash;
    !(d_dev_oe && d_host_oe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("data clash");
  property p_sa_quiet;
    !standalone_n |-> !d_dev_oe;
  endproperty
  a_sa_quiet: assert property (p_sa_quiet) else $error("standalone drive");
  property p_rst;
    disable iff (1'b0) !rst_n |-> irq_out_n && !d_dev_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
  // Slow hosts keep chip select low past the end of the write strobe
  property p_cs_late;
    standalone_n && !bus_style_sel && !write_timing_sel_n && $rose(write_n) |-> !chip_sel_n;
  endproperty
  a_cs_late: assert property (p_cs_late) else $error("select left early");
  c_wr: cover property (!bus_style_sel && !write_n);
  c_ds: cover property (bus_style_sel && read_n != strobe_pol_sel_n);
  c_sa: cover property (!standalone_n);
endmodule : hbs_props

// >>> tb/tb.sv
module tb
  import hbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Starts released, so the first reset is a real falling edge
  logic clk = 1'b0, rst_n = 1'b1, cmd_wr = 1'b0, cmd_rd = 1'b0;
  logic cfg_bus_style = 1'b0, cfg_mux = 1'b0, cfg_latch_pol = 1'b0;
  logic cfg_strobe_low = 1'b0, cfg_cs_early = 1'b0, cfg_standalone = 1'b0;
  logic node_reg_use = 1'b0, irq_req = 1'b0, tx_act1 = 1'b0;
  logic [1:0] cmd_addr = 2'h0;
  logic [15:0] cmd_wdata = 16'h0000, rd_data = 16'h0000, standalone_out_port = 16'hc3a5;
  logic [14:0] node_straps = 15'h2a55, node_regs = 15'h15aa;
  logic [7:0] gpio_out = 8'h00;
  logic [3:0] carry_lo_straps = 4'ha;
  wire logic latch_pol_sel = cfg_latch_pol;
  wire logic tx_en_pol_sel = !cfg_standalone;
  wire logic bus_width_sel = 1'b1, byte_swap_sel_n = 1'b1;
  logic time_unlocked_flag = 1'b0;
  wire logic out_port_strobe = 1'b0, tx_act2 = tx_act1;
  wire logic [7:0] gpio_oe = gpio_out;
  logic [15:0] cmd_rdata, wr_data, standalone_in_port, last_data;
  logic standalone, rx_err_stop_mode, wr_pulse, rd_pulse, in_port_strobe;
  logic tx_en_port1, tx_en_port2;
  logic [4:0] clk_master_id;
  logic [3:0] carry_digit_sel;
  logic [14:0] node_cfg;
  logic [5:0] acc_addr, last_addr;
  logic [7:0] gpio_pin_out, gpio_pin_oe, pin_out;
  int error_cnt = 0, n_tests = 0, n_wr = 0, n_rd = 0;
  hbs_if hb();
  hbs_host i_hbs_host (.clk, .rst_n, .hb(hb), .cfg_bus_style, .cfg_mux, .cfg_latch_pol,
    .cfg_strobe_low, .cfg_cs_early, .cfg_standalone, .cmd_addr, .cmd_wdata, .cmd_wr,
    .cmd_rd, .cmd_rdata);
  hbs_device i_hbs_device (.clk, .rst_n, .hb(hb), .latch_pol_sel, .bus_width_sel,
    .byte_swap_sel_n, .tx_en_pol_sel, .node_straps, .node_regs, .node_reg_use,
    .carry_lo_straps, .irq_req, .time_unlocked_flag, .tx_act1, .tx_act2, .rd_data,
    .gpio_out, .gpio_oe, .standalone_out_port, .out_port_strobe, .standalone,
    .clk_master_id, .carry_digit_sel, .rx_err_stop_mode, .node_cfg, .wr_pulse, .rd_pulse,
    .acc_addr, .wr_data, .standalone_in_port, .in_port_strobe, .pin_out, .gpio_pin_out,
    .gpio_pin_oe, .tx_en_port1, .tx_en_port2);
  hbs_props i_hbs_props (.clk, .rst_n, .chip_sel_n(hb.chip_sel_n), .write_n(hb.write_n),
    .read_n(hb.read_n), .d_host_oe(hb.d_host_oe), .d_dev_oe(hb.d_dev_oe),
    .irq_out_n(hb.irq_out_n), .bus_style_sel(hb.bus_style_sel),
    .addr_mux_sel_n(hb.addr_mux_sel_n), .strobe_pol_sel_n(hb.strobe_pol_sel_n),
    .write_timing_sel_n(hb.write_timing_sel_n), .standalone_n(hb.standalone_n));
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    if (wr_pulse === 1'b1 || rd_pulse === 1'b1)
      last_addr = acc_addr;
    if (wr_pulse === 1'b1)
      last_data = wr_data;
    if (wr_pulse === 1'b1)
      n_wr++;
    if (rd_pulse === 1'b1)
      n_rd++;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("Counts: %0d errors, %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // Straps only count while reset is low, so config moves with it
  task automatic do_reset(input logic [5:0] c);
    rst_n <= 1'b0;
    {cfg_standalone, cfg_cs_early, cfg_strobe_low, cfg_latch_pol, cfg_mux, cfg_bus_style} <= c;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : do_reset
  task automatic cmd(input logic [1:0] a, input logic [15:0] d, input logic w);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_wr <= w;
    cmd_rd <= !w;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    @(posedge clk);
  endtask : cmd
  task automatic xfer(input logic w, input logic [5:0] a);
    cmd(HBS_REG_CTRL, {2'b00, a, 6'h00, w, 1'b1}, 1'b1);
    for (int i = 0; i < 40; i++)
    begin
      cmd(HBS_REG_STAT, 16'h0000, 1'b0);
      if (cmd_rdata[0] === 1'b0)
        break;
    end
    // Device pulse lags the strobe by one cycle
    repeat (3) @(posedge clk);
  endtask : xfer
  task automatic t_bus(input logic [5:0] c, input logic [5:0] a, input logic [15:0] d);
    int w0, r0;
    do_reset(c);
    w0 = n_wr;
    r0 = n_rd;
    cmd(HBS_REG_DATA, d, 1'b1);
    xfer(1'b1, a);
    check(16'(n_wr - w0), 16'h0001);
    check(16'(last_addr), 16'(a));
    check(last_data, d);
    rd_data <= ~d;
    xfer(1'b0, a ^ 6'h3e);
    check(16'(n_rd - r0), 16'h0001);
    check(16'(last_addr), 16'(a ^ 6'h3e));
    cmd(HBS_REG_DATA, 16'h0000, 1'b0);
    check(cmd_rdata, ~d);
  endtask : t_bus
  task automatic t_periph();
    do_reset(6'h10);
    check(16'(standalone), 16'h0000);
    check(16'(node_cfg), 16'h2a55);
    node_reg_use <= 1'b1;
    gpio_out <= 8'ha5;
    irq_req <= 1'b1;
    tx_act1 <= 1'b1;
    repeat (4) @(posedge clk);
    check(16'(node_cfg), 16'h15aa);
    check(16'(gpio_pin_out), 16'h00a5);
    check(16'(gpio_pin_oe), 16'h00a5);
    check(16'(hb.irq_out_n), 16'h0000);
    check(16'(tx_en_port1), 16'h0001);
    check(16'(tx_en_port2), 16'h0001);
    irq_req <= 1'b0;
    repeat (4) @(posedge clk);
    check(16'(hb.irq_out_n), 16'h0001);
  endtask : t_periph
  task automatic t_alone();
    do_reset(6'h3a);
    check(16'(standalone), 16'h0001);
    check(16'(clk_master_id), 16'h001c);
    check(16'(carry_digit_sel), 16'h000e);
    check(16'(rx_err_stop_mode), 16'h0001);
    carry_lo_straps <= 4'h5;
    time_unlocked_flag <= 1'b1;
    // Data pins still low in the first cycle, so the input strobe shows
    cmd(HBS_REG_DATA, 16'h5a5b, 1'b1);
    check(16'(in_port_strobe), 16'h0001);
    repeat (4) @(posedge clk);
    check(16'(carry_digit_sel), 16'h000e);
    check(16'(gpio_pin_out), 16'h00c3);
    check(16'(gpio_pin_oe), 16'h00ff);
    check(16'(tx_en_port1), 16'h0000);
    check(16'(pin_out), 16'h00a5);
    check(standalone_in_port, 16'h5a5b);
    check(16'(in_port_strobe), 16'h0000);
    check(16'(hb.irq_out_n), 16'h0000);
  endtask : t_alone
  initial
  begin
    t_bus(6'h00, 6'h12, 16'h1234);
    t_bus(6'h15, 6'h20, 16'ha55a);
    t_bus(6'h01, 6'h0c, 16'h00ff);
    t_bus(6'h1a, 6'h3a, 16'hf00f);
    t_bus(6'h07, 6'h06, 16'h5aa5);
    t_periph();
    t_alone();
    complete_run();
  end
  initial
  begin
    #400000;
    error_cnt++;
    complete_run();
  end
endmodule : tb
